//--- core/adcc_control.sv
// converter control register two, sample-time registers and conversion sequencer
//
// Overview of operation
// [RULE_01] injected trigger code 111 uses the injected software-start bit as trigger
// [RULE_02] bit 11 set gives left-justified results, clear gives right; resets 0
// [RULE_03] bit 8 enables dma mode when set; resets to 0
// [RULE_04] software sets bit 3, hardware clears it after calibration registers reset
// [RULE_05] calibration reset during a conversion waits until that conversion ends
// [RULE_06] software sets bit 2 to calibrate, hardware clears it when finished
// [RULE_07] bit 1 set converts continuously until cleared; clear means single conversion
// [RULE_08] writing power-on 1 while it reads 0 only wakes the converter
// [RULE_09] writing power-on 1 while it reads 1 starts a conversion
// [RULE_10] writing power-on 0 stops conversion or calibration and powers down
// [RULE_11] a start happens only if no other control bit changes in that write
// [RULE_12] sample codes 000..111 give 3,9,15,30,43,57,73,241 sample cycles
// [RULE_13] software keeps a channel's sample code steady while it is sampled
// [RULE_14] high sample register holds channels 10..15 in bits 17:0, rest zero
// [RULE_15] low sample register holds channels 0..9 in bits 29:0, rest zero
// [RULE_16] injected select 14:12: codes 000..011 timer events, 110 pin event
// [RULE_17] in dma mode each regular result raises one transfer request
`timescale 1ns/10ps

module adcc_control #(
    parameter int CONV_CYCLES = adcc_pkg::ADCC_CONV_CYCLES,
    parameter int CAL_CYCLES = adcc_pkg::ADCC_CAL_CYCLES,
    parameter int CALRST_CYCLES = adcc_pkg::ADCC_CALRST_CYCLES,
    parameter int DATA_W = adcc_pkg::ADCC_DATA_W
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // trigger sources
    input wire logic [3:0] TIMER_EVENT,
    input wire logic TRIGGER_PIN,
    // channel choice from sequence logic
    input wire logic [3:0] REG_CHANNEL,
    input wire logic [3:0] INJ_CHANNEL,
    // converter core
    input wire logic [DATA_W-1:0] CORE_DATA,
    output logic POWER_ON,
    output logic SAMPLING,
    output logic CONVERTING,
    output logic CAL_RESET_ACTIVE,
    output logic CAL_ACTIVE,
    output logic [3:0] CONV_CHANNEL,
    output logic CONV_INJECTED,
    // results
    output logic [15:0] REG_DATA,
    output logic REG_VALID,
    output logic [15:0] INJ_DATA,
    output logic INJ_VALID,
    output logic DMA_REQ
);

    localparam int CNT_W = 16;

    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535 || CAL_CYCLES < 1 || CAL_CYCLES > 65535 ||
        CALRST_CYCLES < 1 || CALRST_CYCLES > 65535) begin : g_bad_count
        $error("adcc_control: timing counts must lie in 1..65535");
    end
    if (DATA_W < 1 || DATA_W > adcc_pkg::ADCC_RES_W) begin : g_bad_width
        $error("adcc_control: DATA_W must lie in 1..16");
    end

    typedef struct packed {
        adcc_pkg::adcc_state_t st;
        logic on;
        logic repeat_conversion;
        logic cal;
        logic cal_register_reset;
        logic dma;
        logic align;
        logic [2:0] inj_trigger_select;
        logic inj_ext_enable;
        logic inj_soft_start;
        logic [47:0] channel_sample_time;
        logic [CNT_W-1:0] cnt;
        logic inj_cur;
        logic inj_pend;
        logic reg_pend;
        logic [3:0] chan;
        logic [15:0] reg_data;
        logic reg_valid;
        logic [15:0] inj_data;
        logic inj_valid;
        logic dma_req;
        logic [31:0] rdata;
        logic [2:0] pin_sync;
        logic pin_level;
    } adcc_regs_t;

    adcc_regs_t r_reg;
    adcc_regs_t r_next;

    // sampling length of a code
    function automatic logic [7:0] sample_len(input logic [2:0] code);
        sample_len = adcc_pkg::ADCC_SMP_CYCLES[code]; // [RULE_12]
    endfunction

    // code of a channel, channel n at bits 3n+2..3n
    function automatic logic [2:0] chan_code(input logic [47:0] codes, input logic [3:0] ch);
        chan_code = codes[ch*adcc_pkg::ADCC_CODE_W +: adcc_pkg::ADCC_CODE_W];
    endfunction

    // readable image of control register two
    function automatic logic [31:0] ctrl_word(input adcc_regs_t s);
        logic [31:0] w;
        w = adcc_pkg::ADCC_CTRL2_RESET;
        w[adcc_pkg::ADCC_BIT_ON] = s.on;
        w[adcc_pkg::ADCC_BIT_REPEAT] = s.repeat_conversion;
        w[adcc_pkg::ADCC_BIT_CAL] = s.cal;
        w[adcc_pkg::ADCC_BIT_CALRST] = s.cal_register_reset;
        w[adcc_pkg::ADCC_BIT_DMA] = s.dma;
        w[adcc_pkg::ADCC_BIT_ALIGN] = s.align;
        w[adcc_pkg::ADCC_BIT_JSEL_LO +: 3] = s.inj_trigger_select;
        w[adcc_pkg::ADCC_BIT_JEXT] = s.inj_ext_enable;
        w[adcc_pkg::ADCC_BIT_JSOFT] = s.inj_soft_start;
        ctrl_word = w;
    endfunction

    // justified result
    function automatic logic [15:0] justify(input logic [DATA_W-1:0] d, input logic left);
        logic [15:0] v;
        v = 16'(d);
        if (left) begin
            v = 16'(v << (adcc_pkg::ADCC_RES_W - DATA_W)); // [RULE_02]
        end
        justify = v;
    endfunction

    logic pin_rise;
    logic sel_event;
    logic inj_trig;
    logic start_ok;
    logic [3:0] start_chan;

    always_comb begin
        r_next = r_reg;
        r_next.reg_valid = 1'b0;
        r_next.inj_valid = 1'b0;
        r_next.dma_req = 1'b0;
        r_next.rdata = 32'h0000_0000;
        start_chan = REG_CHANNEL;

        // pin event: three flops, level moves once the last two agree
        r_next.pin_sync = {r_reg.pin_sync[1:0], TRIGGER_PIN};
        if (r_reg.pin_sync[2] == r_reg.pin_sync[1]) begin
            r_next.pin_level = r_reg.pin_sync[2];
        end
        pin_rise = r_next.pin_level & ~r_reg.pin_level;

        // injected trigger source
        sel_event = 1'b0;
        case (r_reg.inj_trigger_select)
            3'h0, 3'h1, 3'h2, 3'h3: begin
                sel_event = r_reg.inj_ext_enable
                    & TIMER_EVENT[r_reg.inj_trigger_select[1:0]]; // [RULE_16]
            end
            adcc_pkg::ADCC_JSEL_PIN: begin
                sel_event = r_reg.inj_ext_enable & pin_rise; // [RULE_16]
            end
            adcc_pkg::ADCC_JSEL_SOFT: begin
                sel_event = r_reg.inj_soft_start; // [RULE_01]
            end
            default: begin
                sel_event = 1'b0;
            end
        endcase
        inj_trig = r_reg.on & sel_event;
        if (inj_trig) begin
            r_next.inj_pend = 1'b1;
        end

        // sequencer
        case (r_reg.st)
            adcc_pkg::ADCC_IDLE: begin
                if (r_reg.on) begin
                    if (r_reg.cal_register_reset) begin
                        r_next.st = adcc_pkg::ADCC_CALRST;
                        r_next.cnt = CNT_W'(CALRST_CYCLES - 1);
                    end else if (r_reg.cal) begin
                        r_next.st = adcc_pkg::ADCC_CALIB;
                        r_next.cnt = CNT_W'(CAL_CYCLES - 1);
                    end else if (r_reg.inj_pend || r_reg.reg_pend) begin
                        // injected work goes ahead of pending regular work
                        r_next.inj_cur = r_reg.inj_pend;
                        if (r_reg.inj_pend) begin
                            r_next.inj_pend = inj_trig & ~r_reg.inj_soft_start;
                            r_next.inj_soft_start = 1'b0;
                            start_chan = INJ_CHANNEL;
                        end else begin
                            r_next.reg_pend = 1'b0;
                        end
                        r_next.chan = start_chan;
                        r_next.st = adcc_pkg::ADCC_SAMPLE;
                        r_next.cnt = CNT_W'(sample_len( // [RULE_12]
                            chan_code(r_reg.channel_sample_time, start_chan)) - 8'h01);
                    end
                end
            end
            adcc_pkg::ADCC_SAMPLE: begin
                if (r_reg.cnt == '0) begin
                    r_next.st = adcc_pkg::ADCC_CONVERT;
                    r_next.cnt = CNT_W'(CONV_CYCLES - 1);
                end else begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            adcc_pkg::ADCC_CONVERT: begin
                if (r_reg.cnt == '0) begin
                    // back to idle, where a waiting calibration reset goes first
                    r_next.st = adcc_pkg::ADCC_IDLE; // [RULE_05]
                    if (r_reg.inj_cur) begin
                        r_next.inj_data = justify(CORE_DATA, r_reg.align);
                        r_next.inj_valid = 1'b1;
                    end else begin
                        r_next.reg_data = justify(CORE_DATA, r_reg.align);
                        r_next.reg_valid = 1'b1;
                        r_next.dma_req = r_reg.dma; // [RULE_03] [RULE_17]
                        // a start written during the conversion must not be lost
                        r_next.reg_pend = r_reg.reg_pend | r_reg.repeat_conversion; // [RULE_07]
                    end
                end else begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            adcc_pkg::ADCC_CALRST: begin
                if (r_reg.cnt == '0) begin
                    r_next.cal_register_reset = 1'b0; // [RULE_04]
                    r_next.st = adcc_pkg::ADCC_IDLE;
                end else begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            adcc_pkg::ADCC_CALIB: begin
                if (r_reg.cnt == '0) begin
                    r_next.cal = 1'b0; // [RULE_06]
                    r_next.st = adcc_pkg::ADCC_IDLE;
                end else begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            default: begin
                r_next.st = adcc_pkg::ADCC_IDLE;
            end
        endcase

        // register writes come last so a software set beats a hardware clear
        start_ok = ((WDATA ^ ctrl_word(r_reg)) & adcc_pkg::ADCC_CTRL2_CMP_MASK)
            == 32'h0; // [RULE_11]
        if (WR) begin
            case (ADDR)
                adcc_pkg::ADCC_OFF_CTRL2: begin
                    r_next.repeat_conversion = WDATA[adcc_pkg::ADCC_BIT_REPEAT]; // [RULE_07]
                    r_next.dma = WDATA[adcc_pkg::ADCC_BIT_DMA]; // [RULE_03]
                    r_next.align = WDATA[adcc_pkg::ADCC_BIT_ALIGN]; // [RULE_02]
                    r_next.inj_trigger_select = WDATA[adcc_pkg::ADCC_BIT_JSEL_LO +: 3];
                    r_next.inj_ext_enable = WDATA[adcc_pkg::ADCC_BIT_JEXT];
                    r_next.inj_soft_start = WDATA[adcc_pkg::ADCC_BIT_JSOFT];
                    if (WDATA[adcc_pkg::ADCC_BIT_CALRST]) begin
                        r_next.cal_register_reset = 1'b1; // [RULE_04]
                    end
                    if (WDATA[adcc_pkg::ADCC_BIT_CAL]) begin
                        r_next.cal = 1'b1; // [RULE_06]
                    end
                    if (!WDATA[adcc_pkg::ADCC_BIT_ON]) begin
                        // power-down drops all work, including calibration
                        r_next.on = 1'b0; // [RULE_10]
                        r_next.st = adcc_pkg::ADCC_IDLE;
                        r_next.cal = 1'b0;
                        r_next.cal_register_reset = 1'b0;
                        r_next.inj_pend = 1'b0;
                        r_next.reg_pend = 1'b0;
                        r_next.inj_soft_start = 1'b0;
                    end else if (!r_reg.on) begin
                        r_next.on = 1'b1; // [RULE_08]
                    end else if (start_ok) begin
                        r_next.reg_pend = 1'b1; // [RULE_09] [RULE_11]
                    end
                end
                adcc_pkg::ADCC_OFF_SMP_HIGH: begin
                    r_next.channel_sample_time[47:30] = WDATA[17:0]; // [RULE_14]
                end
                adcc_pkg::ADCC_OFF_SMP_LOW: begin
                    r_next.channel_sample_time[29:0] = WDATA[29:0]; // [RULE_15]
                end
                default: begin
                end
            endcase
        end

        // read data for the following cycle; unmapped reads give zero
        if (RD) begin
            case (ADDR)
                adcc_pkg::ADCC_OFF_CTRL2: begin
                    r_next.rdata = ctrl_word(r_reg);
                end
                adcc_pkg::ADCC_OFF_SMP_HIGH: begin
                    r_next.rdata = {14'h0000, r_reg.channel_sample_time[47:30]}; // [RULE_14]
                end
                adcc_pkg::ADCC_OFF_SMP_LOW: begin
                    r_next.rdata = {2'h0, r_reg.channel_sample_time[29:0]}; // [RULE_15]
                end
                adcc_pkg::ADCC_OFF_STATUS: begin
                    r_next.rdata = {22'h0, r_reg.chan, r_reg.inj_cur, r_reg.inj_pend,
                        r_reg.reg_pend, r_reg.st};
                end
                default: begin
                    r_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            r_reg <= '{
                st: adcc_pkg::ADCC_IDLE,
                channel_sample_time: adcc_pkg::ADCC_SMP_RESET,
                default: '0
            };
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs
    assign RDATA = r_reg.rdata;
    assign POWER_ON = r_reg.on;
    assign SAMPLING = r_reg.st == adcc_pkg::ADCC_SAMPLE;
    assign CONVERTING = r_reg.st == adcc_pkg::ADCC_CONVERT;
    assign CAL_RESET_ACTIVE = r_reg.st == adcc_pkg::ADCC_CALRST;
    assign CAL_ACTIVE = r_reg.st == adcc_pkg::ADCC_CALIB;
    assign CONV_CHANNEL = r_reg.chan;
    assign CONV_INJECTED = r_reg.inj_cur;
    assign REG_DATA = r_reg.reg_data;
    assign REG_VALID = r_reg.reg_valid;
    assign INJ_DATA = r_reg.inj_data;
    assign INJ_VALID = r_reg.inj_valid;
    assign DMA_REQ = r_reg.dma_req;

endmodule

//--- core/adcc_pkg.sv
// constants and types for the converter control block
package adcc_pkg;
    // register byte addresses
    localparam logic [7:0] ADCC_OFF_CTRL2 = 8'h08;
    localparam logic [7:0] ADCC_OFF_SMP_HIGH = 8'h0c;
    localparam logic [7:0] ADCC_OFF_SMP_LOW = 8'h10;
    localparam logic [7:0] ADCC_OFF_STATUS = 8'h40;
    localparam int ADCC_ADDR_W = 8;
    // control register two field positions
    localparam int ADCC_BIT_ON = 0;
    localparam int ADCC_BIT_REPEAT = 1;
    localparam int ADCC_BIT_CAL = 2;
    localparam int ADCC_BIT_CALRST = 3;
    localparam int ADCC_BIT_DMA = 8;
    localparam int ADCC_BIT_ALIGN = 11;
    localparam int ADCC_BIT_JSEL_LO = 12;
    localparam int ADCC_BIT_JEXT = 15;
    localparam int ADCC_BIT_JSOFT = 21;
    localparam logic [31:0] ADCC_CTRL2_RESET = 32'h0000_0000;
    // bits other than power-on that a start write must leave unchanged
    localparam logic [31:0] ADCC_CTRL2_CMP_MASK = 32'h0020_f90e;
    // sample time registers
    localparam int ADCC_CHANNELS = 16;
    localparam int ADCC_CODE_W = 3;
    localparam int ADCC_LOW_CHANNELS = 10;
    localparam int ADCC_SMP_HIGH_W = 18;
    localparam int ADCC_SMP_LOW_W = 30;
    localparam logic [47:0] ADCC_SMP_RESET = 48'h0000_0000_0000;
    // injected trigger codes
    localparam logic [2:0] ADCC_JSEL_PIN = 3'h6;
    localparam logic [2:0] ADCC_JSEL_SOFT = 3'h7;
    // sampling durations for codes 000 to 111, in converter cycles
    localparam logic [7:0] ADCC_SMP_CYCLES [8] = '{
        8'h03, 8'h09, 8'h0f, 8'h1e, 8'h2b, 8'h39, 8'h49, 8'hf1
    };
    // default timing counts in clock cycles, then data and result widths in bits
    localparam int ADCC_CONV_CYCLES = 11;
    localparam int ADCC_CAL_CYCLES = 83;
    localparam int ADCC_CALRST_CYCLES = 8;
    localparam int ADCC_DATA_W = 10;
    localparam int ADCC_RES_W = 16;

    typedef enum logic [2:0] {
        ADCC_IDLE,
        ADCC_SAMPLE,
        ADCC_CONVERT,
        ADCC_CALRST,
        ADCC_CALIB
    } adcc_state_t;
endpackage

//--- testbench/adcc_control_monitor.sv
// concurrent checks on the converter control block ports
`timescale 1ns/10ps
module adcc_control_monitor #(
    parameter int CONV_CYCLES = 11,
    parameter int CAL_CYCLES = 83,
    parameter int CALRST_CYCLES = 8
) (
    // clock, reset and register port
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    // converter state
    input wire logic POWER_ON,
    input wire logic SAMPLING,
    input wire logic CONVERTING,
    input wire logic CAL_RESET_ACTIVE,
    input wire logic CAL_ACTIVE,
    // results
    input wire logic REG_VALID,
    input wire logic INJ_VALID,
    input wire logic DMA_REQ
);
    localparam int CONV_LAST = CONV_CYCLES - 1;
    localparam int CAL_LAST = CAL_CYCLES - 1;
    localparam int CALRST_LAST = CALRST_CYCLES - 1;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    chk_high_reserved: assert property (
        $past(RD) && $past(ADDR) == 8'h0c |-> RDATA[31:18] == 14'h0)
        else $error("high sample register reserved bits not zero");
    chk_low_reserved: assert property (
        $past(RD) && $past(ADDR) == 8'h10 |-> RDATA[31:30] == 2'h0)
        else $error("low sample register reserved bits not zero");
    chk_dma_with_result: assert property (DMA_REQ |-> REG_VALID)
        else $error("transfer request without regular result");
    chk_inj_no_dma: assert property (INJ_VALID |-> !DMA_REQ)
        else $error("transfer request on injected result");
    chk_power_down_idle: assert property (
        !POWER_ON |-> !(SAMPLING || CONVERTING || CAL_ACTIVE || CAL_RESET_ACTIVE))
        else $error("activity while powered down");
    chk_calrst_after_conv: assert property (
        CAL_RESET_ACTIVE |-> !CONVERTING && !SAMPLING)
        else $error("calibration reset overlaps a conversion");
    chk_result_after_conv: assert property (
        $fell(CONVERTING) && POWER_ON |-> REG_VALID || INJ_VALID)
        else $error("conversion ended without a result");
    // power-down may legally cut a phase short, so length checks stand aside then
    chk_cal_length: assert property (
        disable iff (RST || !POWER_ON)
        $rose(CAL_ACTIVE) |-> ##CAL_LAST CAL_ACTIVE ##1 !CAL_ACTIVE)
        else $error("calibration length wrong");
    chk_calrst_length: assert property (
        disable iff (RST || !POWER_ON)
        $rose(CAL_RESET_ACTIVE) |-> ##CALRST_LAST CAL_RESET_ACTIVE ##1 !CAL_RESET_ACTIVE)
        else $error("calibration reset length wrong");
    chk_conv_length: assert property (
        disable iff (RST || !POWER_ON)
        $rose(CONVERTING) |-> ##CONV_LAST CONVERTING ##1 !CONVERTING)
        else $error("conversion length wrong");
endmodule

bind adcc_control adcc_control_monitor #(
    .CONV_CYCLES(CONV_CYCLES), .CAL_CYCLES(CAL_CYCLES), .CALRST_CYCLES(CALRST_CYCLES)
) u_monitor (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .POWER_ON(POWER_ON),
    .SAMPLING(SAMPLING), .CONVERTING(CONVERTING), .CAL_RESET_ACTIVE(CAL_RESET_ACTIVE),
    .CAL_ACTIVE(CAL_ACTIVE), .REG_VALID(REG_VALID), .INJ_VALID(INJ_VALID), .DMA_REQ(DMA_REQ)
);

//--- testbench/adcc_core_model.sv
// behavioural converter core giving a fixed raw result
`timescale 1ns/10ps
module adcc_core_model #(
    parameter logic [9:0] VALUE = 10'h2a5
) (
    // converter phase
    input wire logic CONVERTING,
    // raw result
    output logic [9:0] CORE_DATA
);
    // inverted outside conversion so a late sample never looks right
    always_comb begin
        CORE_DATA = CONVERTING ? VALUE : ~VALUE;
    end
endmodule

//--- testbench/test_adcc_control.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module test_adcc_control;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [3:0] TIMER_EVENT = 4'h0;
    logic TRIGGER_PIN = 1'b0;
    logic [3:0] REG_CHANNEL = 4'h0;
    logic [3:0] INJ_CHANNEL = 4'h5;
    logic [9:0] CORE_DATA;
    logic [31:0] RDATA;
    logic [3:0] CONV_CHANNEL;
    logic [15:0] REG_DATA, INJ_DATA;
    logic POWER_ON, SAMPLING, CONVERTING, CAL_RESET_ACTIVE, CAL_ACTIVE;
    logic CONV_INJECTED, REG_VALID, INJ_VALID, DMA_REQ;
    int error_cnt = 0;
    int checked = 0;
    logic [31:0] ctl = 32'h0;
    localparam logic [9:0] VAL = 10'h2a5;
    int smp_len [8] = '{3, 9, 15, 30, 43, 57, 73, 241};
    always #5 CLK = ~CLK;
    // short timing counts keep the run brief
    adcc_control #(.CONV_CYCLES(2), .CAL_CYCLES(4), .CALRST_CYCLES(2)) dut (
        .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .TIMER_EVENT(TIMER_EVENT), .TRIGGER_PIN(TRIGGER_PIN), .REG_CHANNEL(REG_CHANNEL),
        .INJ_CHANNEL(INJ_CHANNEL), .CORE_DATA(CORE_DATA), .POWER_ON(POWER_ON),
        .SAMPLING(SAMPLING),
        .CONVERTING(CONVERTING), .CAL_RESET_ACTIVE(CAL_RESET_ACTIVE), .CAL_ACTIVE(CAL_ACTIVE),
        .CONV_CHANNEL(CONV_CHANNEL), .CONV_INJECTED(CONV_INJECTED), .REG_DATA(REG_DATA),
        .REG_VALID(REG_VALID), .INJ_DATA(INJ_DATA), .INJ_VALID(INJ_VALID), .DMA_REQ(DMA_REQ));
    adcc_core_model model (.CONVERTING(CONVERTING), .CORE_DATA(CORE_DATA));
    task automatic complete_run;
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        cmp(RDATA, exp);
    endtask
    function automatic logic pick(input int w);
        logic [4:0] v;
        v = {CAL_RESET_ACTIVE, CAL_ACTIVE, INJ_VALID, REG_VALID, SAMPLING};
        return v[w];
    endfunction
    // bounded poll; a miss is a mismatch
    task automatic wait_for(input int w, input int lim);
        int n;
        n = 0;
        #1;
        while (pick(w) !== 1'b1 && n < lim) begin
            @(posedge CLK);
            #1;
            n++;
        end
        cmp(32'(n < lim), 32'h1);
    endtask
    task automatic wake_check;
        ctl = 32'h1;
        wr(8'h08, ctl);
        repeat (5) @(posedge CLK);
        #1;
        cmp({POWER_ON, SAMPLING}, 2'b10);
        ctl = 32'h101;
        wr(8'h08, ctl);
        repeat (5) @(posedge CLK);
        #1;
        cmp({SAMPLING, CONVERTING}, 2'b00);
    endtask
    task automatic conv_once(input logic [7:0] a, input logic [31:0] d, input int code,
        input logic [15:0] exp);
        int n;
        wr(a, d);
        wr(8'h08, ctl);
        wait_for(0, 20);
        cmp({CONV_INJECTED, CONV_CHANNEL}, {1'b0, REG_CHANNEL});
        n = 0;
        while (SAMPLING === 1'b1 && n < 300) begin
            @(posedge CLK);
            #1;
            n++;
        end
        cmp(32'(n), 32'(smp_len[code]));
        wait_for(1, 10);
        cmp(REG_DATA, exp);
        cmp(DMA_REQ, ctl[8]);
    endtask
    task automatic repeat_check;
        int n;
        ctl = 32'h3;
        wr(8'h08, ctl);
        wr(8'h08, ctl);
        n = 0;
        repeat (60) begin
            @(posedge CLK);
            #1;
            if (REG_VALID === 1'b1) n++;
        end
        cmp(32'(n > 3), 32'h1);
        ctl = 32'h1;
        wr(8'h08, ctl);
        repeat (20) @(posedge CLK);
        #1;
        cmp(SAMPLING, 1'b0);
    endtask
    // hardware must drop the bit once its job is done
    task automatic selfclear_check(input int b, input int w);
        wr(8'h08, ctl | (32'h1 << b));
        wait_for(w, 300);
        repeat (10) @(posedge CLK);
        rd(8'h08, ctl);
    endtask
    task automatic power_off_check;
        wr(8'h10, 32'h7);
        wr(8'h08, ctl);
        wait_for(0, 20);
        ctl = 32'h0;
        wr(8'h08, ctl);
        #1;
        cmp({POWER_ON, SAMPLING}, 2'b00);
        rd(8'h08, 32'h0);
    endtask
    task automatic inj_check(input logic [31:0] c, input logic [3:0] ev, input logic pin);
        ctl = c;
        wr(8'h08, ctl);
        TIMER_EVENT <= ev;
        TRIGGER_PIN <= pin;
        @(posedge CLK);
        TIMER_EVENT <= 4'h0;
        wait_for(2, 300);
        cmp({CONV_INJECTED, CONV_CHANNEL}, {1'b1, INJ_CHANNEL});
        @(posedge CLK);
        TRIGGER_PIN <= 1'b0;
        cmp(INJ_DATA, {6'h0, VAL});
    endtask
    initial begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        rd(8'h08, 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h0c, 32'h0003_ffff);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, 32'h3fff_ffff);
        wake_check;
        for (int c = 0; c < 8; c++) conv_once(8'h10, 32'(c), c, {6'h0, VAL});
        @(posedge CLK);
        REG_CHANNEL <= 4'hb;
        conv_once(8'h0c, 32'h0000_0010, 2, {6'h0, VAL});
        @(posedge CLK);
        REG_CHANNEL <= 4'h0;
        ctl = 32'h901;
        wr(8'h08, ctl);
        conv_once(8'h10, 32'h0, 0, {VAL, 6'h0});
        ctl = 32'h801;
        wr(8'h08, ctl);
        conv_once(8'h10, 32'h0, 0, {VAL, 6'h0});
        repeat_check;
        selfclear_check(2, 3);
        wr(8'h10, 32'h1);
        wr(8'h08, ctl);
        wait_for(0, 20);
        selfclear_check(3, 4);
        power_off_check;
        wr(8'h10, 32'h0);
        // wake only; timer events with the external enable clear must be ignored
        ctl = 32'h1;
        wr(8'h08, ctl);
        TIMER_EVENT <= 4'hf;
        @(posedge CLK);
        TIMER_EVENT <= 4'h0;
        repeat (20) @(posedge CLK);
        rd(8'h40, 32'h0);
        cmp({POWER_ON, SAMPLING, CONV_INJECTED}, 3'b100);
        inj_check(32'h0020_7001, 4'h0, 1'b0);
        inj_check(32'h0000_9001, 4'h2, 1'b0);
        inj_check(32'h0000_e001, 4'h0, 1'b1);
        complete_run;
    end
endmodule
